/* rtl/edsb_top.sv */
// diagnostic and identification register bank with adaptive link timeout
// assumes status inputs on sys_clk, link clock asynchronous and sampled here
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "edsb_defines.svh"

module edsb_top #(
  parameter logic [7:0] MODEL0 = `EDSB_ID_MODEL0, // identifier values arbitrary
  parameter logic [7:0] MODEL1 = `EDSB_ID_MODEL1,
  parameter logic [7:0] MODEL2 = `EDSB_ID_MODEL2,
  parameter logic [7:0] MODEL3 = `EDSB_ID_MODEL3,
  parameter logic [7:0] MODEL4 = `EDSB_ID_MODEL4,
  parameter logic [7:0] SW_DIGIT = `EDSB_ASCII_ZERO + `EDSB_SW_VERSION,
  parameter logic [7:0] MAKER0 = `EDSB_ID_MAKER0,
  parameter logic [7:0] MAKER1 = `EDSB_ID_MAKER1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire edsb_pkg::edsb_bus_s bus,
  input wire edsb_pkg::edsb_stat_s stat,
  input wire logic lk_clk,
  output logic [7:0] rdata,
  output logic frame_err,
  output logic frame_end,
  output logic link_idle,
  output logic wc_restore
);
  import edsb_pkg::*;

  edsb_state_s s_q;
  edsb_state_s s_d;

  logic rise;
  logic clr;
  logic [11:0] tmo;
  logic [12:0] dbl;

  function automatic logic hit(input logic [31:0] v, input logic [31:0] lim);
    hit = (lim != 32'h0) && (v >= lim);
  endfunction

  function automatic logic [11:0] sat_inc(input logic [11:0] v);
    sat_inc = (v == `EDSB_CNT_MAX) ? v : v + 12'h1;
  endfunction

  always_comb begin
    s_d = s_q;
    rise = s_q.lk_sync[1] & ~s_q.lk_prev;
    clr = bus.wr && (bus.addr == `EDSB_OFF_CMD) && (bus.wdata == `EDSB_CMD_CLEAR);
    // link clock edge finding and period measurement
    s_d.lk_sync = {s_q.lk_sync[0], lk_clk};
    s_d.lk_prev = s_q.lk_sync[1];
    dbl = {s_q.per, 1'b0};
    if (dbl < 13'(`EDSB_TO_MIN_CYC)) begin
      tmo = 12'(`EDSB_TO_MIN_CYC);
    end else if (dbl > 13'(`EDSB_TO_MAX_CYC)) begin
      tmo = 12'(`EDSB_TO_MAX_CYC);
    end else begin
      tmo = dbl[11:0];
    end
    s_d.frame_end = 1'b0;
    if (rise) begin
      s_d.per = s_q.per_cnt;
      s_d.per_cnt = 12'h1;
      s_d.idle_cnt = 12'h0;
      s_d.idle = 1'b0;
    end else begin
      s_d.per_cnt = sat_inc(s_q.per_cnt);
      s_d.idle_cnt = sat_inc(s_q.idle_cnt);
      if (!s_q.idle && (s_q.idle_cnt >= tmo)) begin
        s_d.frame_end = 1'b1;
        s_d.idle = 1'b1;
      end
    end
    // command register and flag clearing; a set in the same cycle wins
    if (bus.wr && (bus.addr == `EDSB_OFF_CMD)) begin
      s_d.cmd = bus.wdata;
    end
    if (clr) begin
      s_d.fault = s_q.fault & ~`EDSB_FAULT_CLR_MASK;
      s_d.swarn[`EDSB_W_NVM] = 1'b0;
    end
    if (hit(stat.wc, stat.wc_lim)) begin
      s_d.fault[`EDSB_F_WC] = 1'b1;
    end
    if (hit(32'(stat.acc), 32'(stat.acc_lim))) begin
      s_d.fault[`EDSB_F_ACC] = 1'b1;
    end
    if (hit(32'(stat.spd), 32'(stat.spd_lim))) begin
      s_d.fault[`EDSB_F_SPD] = 1'b1;
    end
    if (stat.gear_err) begin
      s_d.fault[`EDSB_F_GEAR] = 1'b1;
    end
    if (stat.save_fail) begin
      s_d.fault[`EDSB_F_SAVE] = 1'b1;
    end
    if (stat.ofs_fail) begin
      s_d.fault[`EDSB_F_OFS] = 1'b1;
    end
    if (stat.sync_fail) begin
      s_d.fault[`EDSB_F_SYNC] = 1'b1;
    end
    if (stat.cfg_fail) begin
      s_d.fault[`EDSB_F_CFG] = 1'b1;
    end
    s_d.restore = stat.save_fail;
    s_d.swarn[`EDSB_W_RESYNC] = stat.resync_req;
    s_d.frame_err = stat.core_err & ~stat.resync_req;
    if (stat.sync_nvm_fail) begin
      s_d.swarn[`EDSB_W_NVM] = 1'b1;
    end
    // temperature hysteresis
    if (stat.temp > `EDSB_T_WARN_SET) begin
      s_d.swarn[`EDSB_W_TEMP] = 1'b1;
    end else if (stat.temp < `EDSB_T_RELEASE) begin
      s_d.swarn[`EDSB_W_TEMP] = 1'b0;
    end
    if (stat.temp > `EDSB_T_ERR_SET) begin
      s_d.serr = 1'b1;
    end else if (stat.temp < `EDSB_T_RELEASE) begin
      s_d.serr = 1'b0;
    end
    // read port, data in the cycle after the strobe only
    s_d.rdata = 8'h00;
    if (bus.rd) begin
      if (bus.addr == `EDSB_OFF_CMD) begin
        s_d.rdata = s_q.cmd;
      end else if (bus.addr == `EDSB_OFF_FAULT) begin
        s_d.rdata = s_q.fault;
      end else if (bus.addr == `EDSB_OFF_SWARN) begin
        s_d.rdata = s_q.swarn;
      end else if (bus.addr == `EDSB_OFF_SERR_LO) begin
        s_d.rdata = {7'h00, s_q.serr};
      end else if (bus.addr == `EDSB_OFF_SERR_HI) begin
        s_d.rdata = 8'h00;
      end else if (bus.addr == `EDSB_OFF_MODEL0) begin
        s_d.rdata = MODEL0;
      end else if (bus.addr == `EDSB_OFF_MODEL1) begin
        s_d.rdata = MODEL1;
      end else if (bus.addr == `EDSB_OFF_MODEL2) begin
        s_d.rdata = MODEL2;
      end else if (bus.addr == `EDSB_OFF_MODEL3) begin
        s_d.rdata = MODEL3;
      end else if (bus.addr == `EDSB_OFF_MODEL4) begin
        s_d.rdata = MODEL4;
      end else if (bus.addr == `EDSB_OFF_SWVER) begin
        s_d.rdata = SW_DIGIT;
      end else if (bus.addr == `EDSB_OFF_MAKER0) begin
        s_d.rdata = MAKER0;
      end else if (bus.addr == `EDSB_OFF_MAKER1) begin
        s_d.rdata = MAKER1;
      end else begin
        s_d.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.idle <= 1'b1;
      s_q.lk_sync <= {2{`EDSB_LK_IDLE}};
      s_q.lk_prev <= `EDSB_LK_IDLE;
      s_q.cmd <= `EDSB_CMD_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign frame_err = s_q.frame_err;
  assign frame_end = s_q.frame_end;
  assign link_idle = s_q.idle;
  assign wc_restore = s_q.restore;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence clr_cmd_s;
    bus.wr && (bus.addr == `EDSB_OFF_CMD) && (bus.wdata == `EDSB_CMD_CLEAR);
  endsequence

  sequence fault_rd_s;
    bus.rd && (bus.addr == `EDSB_OFF_FAULT);
  endsequence

  fault_clear_a: assert property (
    clr_cmd_s ##0 (!hit(stat.wc, stat.wc_lim) && !stat.gear_err && !stat.save_fail
      && !hit(32'(stat.acc), 32'(stat.acc_lim)) && !hit(32'(stat.spd), 32'(stat.spd_lim)))
    |=> (s_q.fault[4:0] == 5'h00))
    else $error("clearable faults not cleared");

  fault_read_a: assert property (
    fault_rd_s |=> (rdata == $past(s_q.fault)))
    else $error("fault register read mismatch");

  wc_limit_a: assert property (
    (stat.wc_lim != 32'h0 && stat.wc >= stat.wc_lim) |=> s_q.fault[`EDSB_F_WC])
    else $error("work cycle flag not set");

  wc_reassert_a: assert property (
    clr_cmd_s ##0 (stat.wc_lim != 32'h0 && stat.wc >= stat.wc_lim) |=> s_q.fault[`EDSB_F_WC])
    else $error("work cycle flag lost on clear");

  wc_off_a: assert property (
    (stat.wc_lim == 32'h0) ##0 clr_cmd_s |=> !s_q.fault[`EDSB_F_WC])
    else $error("work cycle flag with limit zero");

  acc_peak_a: assert property (
    (stat.acc_lim != 18'h0 && stat.acc >= stat.acc_lim) |=> s_q.fault[`EDSB_F_ACC])
    else $error("acceleration flag not set");

  spd_peak_a: assert property (
    (stat.spd_lim != 16'h0 && stat.spd >= stat.spd_lim) |=> s_q.fault[`EDSB_F_SPD])
    else $error("speed flag not set");

  gear_err_a: assert property (
    stat.gear_err |=> s_q.fault[`EDSB_F_GEAR])
    else $error("gear error flag not set");

  save_err_a: assert property (
    stat.save_fail |=> (s_q.fault[`EDSB_F_SAVE] && wc_restore))
    else $error("save failure not flagged");

  sticky_faults_a: assert property (
    clr_cmd_s |=> ((s_q.fault[7:5] & $past(s_q.fault[7:5])) == $past(s_q.fault[7:5])))
    else $error("persistent fault cleared by command");

  ofs_err_a: assert property (
    stat.ofs_fail |=> s_q.fault[`EDSB_F_OFS] [*3])
    else $error("offset fault not held");

  sync_err_a: assert property (
    stat.sync_fail |=> s_q.fault[`EDSB_F_SYNC] [*3])
    else $error("sync fault not held");

  cfg_err_a: assert property (
    stat.cfg_fail |=> s_q.fault[`EDSB_F_CFG] [*3])
    else $error("config fault not held");

  resync_warn_a: assert property (
    stat.resync_req |=> (s_q.swarn[`EDSB_W_RESYNC] && !frame_err))
    else $error("resync warning or frame error wrong");

  nvm_warn_a: assert property (
    stat.sync_nvm_fail |=> s_q.swarn[`EDSB_W_NVM])
    else $error("sync memory warning not set");

  temp_warn_a: assert property (
    (stat.temp > `EDSB_T_WARN_SET) |=> s_q.swarn[`EDSB_W_TEMP])
    else $error("temperature warning not set");

  temp_hold_a: assert property (
    (s_q.swarn[`EDSB_W_TEMP] && stat.temp >= `EDSB_T_RELEASE) |=> s_q.swarn[`EDSB_W_TEMP])
    else $error("temperature warning released early");

  temp_err_a: assert property (
    (stat.temp > `EDSB_T_ERR_SET) |=> s_q.serr)
    else $error("temperature error not set");

  temp_err_rel_a: assert property (
    (stat.temp < `EDSB_T_RELEASE) |=> !s_q.serr)
    else $error("temperature error not released");

  rsvd_zero_a: assert property (
    bus.rd && (bus.addr == `EDSB_OFF_SERR_HI) |=> (rdata == 8'h00))
    else $error("reserved error register not zero");

  ver_ascii_a: assert property (
    bus.rd && (bus.addr == `EDSB_OFF_SWVER) |=> (rdata == SW_DIGIT))
    else $error("version byte wrong");

  model_id_a: assert property (
    bus.rd && (bus.addr == `EDSB_OFF_MODEL4) |=> (rdata == MODEL4))
    else $error("model byte wrong");

  maker_id_a: assert property (
    bus.rd && (bus.addr == `EDSB_OFF_MAKER1) |=> (rdata == MAKER1))
    else $error("maker byte wrong");

  timeout_min_a: assert property (
    frame_end |-> ($past(s_q.idle_cnt) >= 12'(`EDSB_TO_MIN_CYC)))
    else $error("frame end before least timeout");

  timeout_max_a: assert property (
    frame_end |-> ($past(s_q.idle_cnt) <= 12'(`EDSB_TO_MAX_CYC)))
    else $error("frame end after longest timeout");

  temp_warn_rel_a: assert property (
    (stat.temp < `EDSB_T_RELEASE) |=> !s_q.swarn[`EDSB_W_TEMP])
    else $error("temperature warning not released");

  temp_err_hold_a: assert property (
    (s_q.serr && stat.temp >= `EDSB_T_RELEASE) |=> s_q.serr)
    else $error("temperature error released early");

  warn_quiet_a: assert property (
    (!s_q.swarn[`EDSB_W_TEMP] && stat.temp <= `EDSB_T_WARN_SET) |=> !s_q.swarn[`EDSB_W_TEMP])
    else $error("temperature warning set too low");

  err_quiet_a: assert property (
    (!s_q.serr && stat.temp <= `EDSB_T_ERR_SET) |=> !s_q.serr)
    else $error("temperature error set too low");

  resync_follow_a: assert property (
    !stat.resync_req |=> !s_q.swarn[`EDSB_W_RESYNC])
    else $error("resync warning stuck");

  frame_err_set_a: assert property (
    (stat.core_err && !stat.resync_req) |=> frame_err)
    else $error("frame error not passed");

  nvm_clear_a: assert property (
    clr_cmd_s ##0 !stat.sync_nvm_fail |=> !s_q.swarn[`EDSB_W_NVM])
    else $error("sync memory warning not cleared");

  acc_reassert_a: assert property (
    clr_cmd_s ##0 hit(32'(stat.acc), 32'(stat.acc_lim)) |=> s_q.fault[`EDSB_F_ACC])
    else $error("acceleration flag lost on clear");

  spd_reassert_a: assert property (
    clr_cmd_s ##0 hit(32'(stat.spd), 32'(stat.spd_lim)) |=> s_q.fault[`EDSB_F_SPD])
    else $error("speed flag lost on clear");

  gear_clear_a: assert property (
    clr_cmd_s ##0 !stat.gear_err |=> !s_q.fault[`EDSB_F_GEAR])
    else $error("gear error flag not cleared");

  save_clear_a: assert property (
    clr_cmd_s ##0 !stat.save_fail |=> !s_q.fault[`EDSB_F_SAVE])
    else $error("save error flag not cleared");

  restore_pulse_a: assert property (
    !stat.save_fail |=> !wc_restore)
    else $error("restore without save failure");

  rd_idle_a: assert property (
    !bus.rd |=> (rdata == 8'h00))
    else $error("read data without read strobe");

  serr_read_a: assert property (
    bus.rd && (bus.addr == `EDSB_OFF_SERR_LO) |=> (rdata == {7'h00, $past(s_q.serr)}))
    else $error("sensor error register read wrong");

  swarn_read_a: assert property (
    bus.rd && (bus.addr == `EDSB_OFF_SWARN) |=> (rdata == $past(s_q.swarn)))
    else $error("sensor warning register read wrong");

  swarn_unused_a: assert property (
    (s_q.swarn[2:0] == 3'h0) && (s_q.swarn[5:4] == 2'h0))
    else $error("unused warning bits set");

  model0_a: assert property (
    bus.rd && (bus.addr == `EDSB_OFF_MODEL0) |=> (rdata == MODEL0))
    else $error("first model byte wrong");

  maker0_a: assert property (
    bus.rd && (bus.addr == `EDSB_OFF_MAKER0) |=> (rdata == MAKER0))
    else $error("first maker byte wrong");

  cmd_write_a: assert property (
    bus.wr && (bus.addr == `EDSB_OFF_CMD) |=> (s_q.cmd == $past(bus.wdata)))
    else $error("command register not written");

  ro_write_a: assert property (
    (bus.wr && (bus.addr == `EDSB_OFF_FAULT))
    |=> ((s_q.fault & $past(s_q.fault)) == $past(s_q.fault)))
    else $error("fault register changed by a write");

  end_idle_a: assert property (
    frame_end |-> link_idle)
    else $error("frame end without idle link");

  end_pulse_a: assert property (
    frame_end |=> !frame_end)
    else $error("frame end longer than one cycle");

  link_wake_a: assert property (
    rise |=> !link_idle)
    else $error("link edge did not wake the link");

endmodule

`default_nettype wire

/* common/edsb_defines.svh */
// offsets, field positions, thresholds and timing figures of the diagnostic bank
// assumes a 250 MHz system clock and byte-wide register access
`ifndef EDSB_DEFINES_SVH
`define EDSB_DEFINES_SVH

`define EDSB_OFF_CMD 8'h70
`define EDSB_OFF_FAULT 8'h74
`define EDSB_OFF_SWARN 8'h75
`define EDSB_OFF_SERR_LO 8'h76
`define EDSB_OFF_SERR_HI 8'h77
`define EDSB_OFF_MODEL0 8'h78
`define EDSB_OFF_MODEL1 8'h79
`define EDSB_OFF_MODEL2 8'h7A
`define EDSB_OFF_MODEL3 8'h7B
`define EDSB_OFF_MODEL4 8'h7C
`define EDSB_OFF_SWVER 8'h7D
`define EDSB_OFF_MAKER0 8'h7E
`define EDSB_OFF_MAKER1 8'h7F

`define EDSB_CMD_CLEAR 8'h08
`define EDSB_CMD_RESET 8'h00
`define EDSB_FAULT_CLR_MASK 8'h1F

`define EDSB_F_WC 0
`define EDSB_F_ACC 1
`define EDSB_F_SPD 2
`define EDSB_F_GEAR 3
`define EDSB_F_SAVE 4
`define EDSB_F_OFS 5
`define EDSB_F_SYNC 6
`define EDSB_F_CFG 7
`define EDSB_W_RESYNC 3
`define EDSB_W_NVM 6
`define EDSB_W_TEMP 7

`define EDSB_T_WARN_SET 8'h5A
`define EDSB_T_ERR_SET 8'h64
`define EDSB_T_RELEASE 8'h55

`define EDSB_CLK_NS 4
`define EDSB_TO_MIN_NS 700
`define EDSB_TO_MAX_NS 8000
`define EDSB_TO_MIN_CYC ((`EDSB_TO_MIN_NS + `EDSB_CLK_NS - 1) / `EDSB_CLK_NS)
`define EDSB_TO_MAX_CYC (`EDSB_TO_MAX_NS / `EDSB_CLK_NS)
`define EDSB_CNT_MAX 12'hFFF
`define EDSB_LK_IDLE 1'b1

// identifier values arbitrary
`define EDSB_ID_MODEL0 8'h51
`define EDSB_ID_MODEL1 8'h58
`define EDSB_ID_MODEL2 8'h52
`define EDSB_ID_MODEL3 8'h37
`define EDSB_ID_MODEL4 8'h5A
`define EDSB_ASCII_ZERO 8'h30
`define EDSB_SW_VERSION 8'h01
`define EDSB_ID_MAKER0 8'h51
`define EDSB_ID_MAKER1 8'h78

`endif

/* common/edsb_pkg.sv */
// types of the diagnostic bank: bus request, status inputs, module state
// assumes the defines header for all figures
package edsb_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } edsb_bus_s;

  typedef struct packed {
    logic [31:0] wc;
    logic [31:0] wc_lim;
    logic [17:0] acc;
    logic [17:0] acc_lim;
    logic [15:0] spd;
    logic [15:0] spd_lim;
    logic gear_err;
    logic save_fail;
    logic ofs_fail;
    logic sync_fail;
    logic cfg_fail;
    logic resync_req;
    logic sync_nvm_fail;
    logic core_err;
    logic [7:0] temp;
  } edsb_stat_s;

  typedef struct packed {
    logic [1:0] lk_sync;
    logic lk_prev;
    logic [11:0] per_cnt;
    logic [11:0] per;
    logic [11:0] idle_cnt;
    logic idle;
    logic frame_end;
    logic [7:0] fault;
    logic [7:0] swarn;
    logic serr;
    logic [7:0] cmd;
    logic [7:0] rdata;
    logic frame_err;
    logic restore;
  } edsb_state_s;

endpackage

/* tb/edsb_link_master.sv */
// link master model: bursts of link clock while run is high
// assumes the bench raises run for a frame and lowers it after; the clock rests high
`timescale 1ns/1ps
`default_nettype none

module edsb_link_master #(
  parameter int HALF_NS = 40
) (
  input wire logic run,
  output logic lk_clk
);
  initial lk_clk = 1'b1;
  // 80 ns link period; bursts start 1 ns off the system clock edges
  always begin
    wait (run);
    #1;
    while (run) begin
      #HALF_NS lk_clk = 1'b0;
      #HALF_NS lk_clk = 1'b1;
    end
  end
endmodule

`default_nettype wire

/* tb/test_encoder_diagnostic_status_bank.sv */
// self-checking bench of the diagnostic bank: ids, fault flags, warnings, link timeout
// assumes the link master model on lk_clk and the bank on a 250 MHz sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "edsb_defines.svh"

module test_encoder_diagnostic_status_bank;
  import edsb_pkg::*;
  logic sys_clk;
  logic rst;
  logic lk_clk;
  logic run;
  edsb_bus_s bus;
  edsb_stat_s stat;
  logic [7:0] rdata;
  logic frame_err;
  logic frame_end;
  logic link_idle;
  logic wc_restore;
  int miscompares;
  int n_compared;
  int cyc;

  edsb_top edsb_top_i (
    .sys_clk(sys_clk), .rst(rst), .bus(bus), .stat(stat), .lk_clk(lk_clk),
    .rdata(rdata), .frame_err(frame_err), .frame_end(frame_end),
    .link_idle(link_idle), .wc_restore(wc_restore));
  edsb_link_master edsb_link_master_i (.run(run), .lk_clk(lk_clk));

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk) bus.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk) bus.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task automatic t_ids();
    logic [7:0] ids [8];
    ids = '{`EDSB_ID_MODEL0, `EDSB_ID_MODEL1, `EDSB_ID_MODEL2, `EDSB_ID_MODEL3,
      `EDSB_ID_MODEL4, `EDSB_ASCII_ZERO + `EDSB_SW_VERSION,
      `EDSB_ID_MAKER0, `EDSB_ID_MAKER1};
    for (int i = 0; i < 8; i++) begin
      rd(8'h78 + 8'(i), ids[i]);
    end
    rd(8'h77, 8'h00);
    rd(8'h76, 8'h00);
    rd(8'h00, 8'h00);
  endtask

  task automatic t_faults();
    @(posedge sys_clk);
    stat.wc <= 32'h5;
    stat.wc_lim <= 32'h5;
    stat.acc <= 18'hA;
    stat.acc_lim <= 18'hA;
    stat.spd <= 16'h3;
    stat.spd_lim <= 16'h3;
    stat.gear_err <= 1'b1;
    stat.save_fail <= 1'b1;
    @(posedge sys_clk);
    stat.gear_err <= 1'b0;
    stat.save_fail <= 1'b0;
    #1 chk({7'h0, wc_restore}, 8'h01);
    rd(`EDSB_OFF_FAULT, 8'h1F);
    wr(`EDSB_OFF_FAULT, 8'hFF);
    rd(`EDSB_OFF_FAULT, 8'h1F);
    @(posedge sys_clk);
    stat.acc <= 18'h0;
    stat.spd <= 16'h0;
    wr(`EDSB_OFF_CMD, `EDSB_CMD_CLEAR);
    rd(`EDSB_OFF_FAULT, 8'h01);
    rd(`EDSB_OFF_CMD, `EDSB_CMD_CLEAR);
    @(posedge sys_clk) stat.wc_lim <= 32'h6;
    wr(`EDSB_OFF_CMD, `EDSB_CMD_CLEAR);
    rd(`EDSB_OFF_FAULT, 8'h00);
    @(posedge sys_clk) stat.spd <= 16'h4;
    rd(`EDSB_OFF_FAULT, 8'h04);
    @(posedge sys_clk) stat.spd <= 16'h0;
    wr(`EDSB_OFF_CMD, `EDSB_CMD_CLEAR);
    rd(`EDSB_OFF_FAULT, 8'h00);
  endtask

  // hysteresis walk: 90 holds off, 91 sets warn, 101 sets error, 86 holds, 84 releases
  task automatic t_temp();
    logic [7:0] t [5];
    logic [4:0] w;
    logic [4:0] e;
    t = '{8'h5A, 8'h5B, 8'h65, 8'h56, 8'h54};
    w = 5'b01110;
    e = 5'b01100;
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk) stat.temp <= t[i];
      rd(`EDSB_OFF_SWARN, {w[i], 7'h00});
      rd(`EDSB_OFF_SERR_LO, {7'h00, e[i]});
    end
  endtask

  task automatic t_warn();
    @(posedge sys_clk);
    stat.resync_req <= 1'b1;
    stat.core_err <= 1'b1;
    rd(`EDSB_OFF_SWARN, 8'h08);
    chk({7'h0, frame_err}, 8'h00);
    @(posedge sys_clk) stat.resync_req <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk({7'h0, frame_err}, 8'h01);
    @(posedge sys_clk);
    stat.core_err <= 1'b0;
    stat.sync_nvm_fail <= 1'b1;
    @(posedge sys_clk) stat.sync_nvm_fail <= 1'b0;
    rd(`EDSB_OFF_SWARN, 8'h40);
    wr(`EDSB_OFF_CMD, `EDSB_CMD_CLEAR);
    rd(`EDSB_OFF_SWARN, 8'h00);
  endtask

  task automatic t_sticky();
    @(posedge sys_clk);
    stat.ofs_fail <= 1'b1;
    stat.sync_fail <= 1'b1;
    stat.cfg_fail <= 1'b1;
    @(posedge sys_clk);
    stat.ofs_fail <= 1'b0;
    stat.sync_fail <= 1'b0;
    stat.cfg_fail <= 1'b0;
    wr(`EDSB_OFF_CMD, `EDSB_CMD_CLEAR);
    rd(`EDSB_OFF_FAULT, 8'hE0);
  endtask

  // 80 ns link: timeout clamps to 175 cycles after the last detected rise
  task automatic t_link();
    int n;
    @(posedge sys_clk) run <= 1'b1;
    repeat (100) @(posedge sys_clk);
    #1 chk({7'h0, link_idle}, 8'h00);
    @(posedge sys_clk) run <= 1'b0;
    n = 0;
    while (frame_end !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk({7'h0, n >= 175 && n <= 205}, 8'h01);
    chk({7'h0, link_idle}, 8'h01);
    @(posedge sys_clk);
    #1 chk({7'h0, frame_end}, 8'h00);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    rst = 1'b1;
    bus = '0;
    stat = '0;
    run = 1'b0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_ids();
    t_faults();
    t_temp();
    t_warn();
    t_sticky();
    t_link();
    tally_and_finish();
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end
endmodule

`default_nettype wire
